/* csp_pkg.sv */
package csp_pkg;
  // Avalon register word indices (byte address = index * 4)
  localparam logic [3:0] CSP_CTRL_IDX = 4'h0;
  localparam logic [3:0] CSP_HWCFG_IDX = 4'h1;
  localparam logic [3:0] CSP_MACHINE_CHECK_SYNDROME_REG_IDX = 4'h2;
  localparam logic [3:0] CSP_STATUS_IDX = 4'h3;
  localparam logic [3:0] CSP_IRQ_STAT_IDX = 4'h4;
  localparam logic [3:0] CSP_IRQ_MASK_IDX = 4'h5;
  localparam logic [3:0] CSP_WAKE_IDX = 4'h6;
  // Control register fields
  localparam int CSP_CTRL_WE_BIT = 0;
  localparam int CSP_CTRL_CHK_BIT = 1;
  // Hardware configuration fields
  localparam int CSP_HW_DOZE_BIT = 0;
  localparam int CSP_HW_NAP_BIT = 1;
  localparam int CSP_HW_SLEEP_BIT = 2;
  // Interrupt status fields
  localparam int CSP_IRQ_MCHK_BIT = 0;
  localparam int CSP_IRQ_CHK_BIT = 1;
  localparam int CSP_IRQ_HALT_BIT = 2;
  localparam int CSP_IRQ_STOP_BIT = 3;
  localparam int CSP_IRQ_BR_BIT = 4;
  localparam int CSP_IRQ_W = 5;
  // Branch prefetch status codes
  localparam logic [1:0] CSP_BR_NONE = 2'h0;
  localparam logic [1:0] CSP_BR_NOT_TAKEN = 2'h2;
  localparam logic [1:0] CSP_BR_TAKEN = 2'h3;
  // Processor status codes, top five bits
  localparam logic [4:0] CSP_PS_HALTED = 5'h08;
  localparam logic [4:0] CSP_PS_STOPPED = 5'h09;
  localparam logic [4:0] CSP_PS_CHKSTOP = 5'h0b;
  localparam logic [4:0] CSP_PS_COMPLETE = 5'h10;
  localparam logic [4:0] CSP_PS_STALLED = 5'h00;
  // Reset values
  localparam logic [31:0] CSP_ZERO32 = 32'h0;
  typedef enum {CSP_RUN, CSP_HALT, CSP_STOP, CSP_CHKSTOP} csp_state_e;
endpackage : csp_pkg

/* csp_core_status.sv */
// Behaviour
// - Branch status 0x none, 10 not-taken, 11 taken
// - Prefetch only on predict-taken buffer hit
// - Branch status updated on core clock
// - Machine check out follows syndrome bits
// - Checkstop out once checkstop state entered
// - Halted acknowledge high only while halted
// - Stopped acknowledge high only while stopped
// - Doze/nap/sleep equal wait-enable AND config bit
// - Size qualifier 0 for 32-bit, 1 for 16-bit
// - Page qualifier 0 fixed, 1 variable length
// - Status code halted, stopped, checkstop encodings
// - Wake-up on valid pending interrupt or request
`timescale 1ns/1ns
module csp_core_status
  import csp_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [1:0] AVS_RESPONSE,
  // Core events
  input wire logic BTB_HIT,
  input wire logic BTB_PREDICT_TAKEN,
  input wire logic BR_RESOLVE,
  input wire logic BR_TAKEN,
  input wire logic MCHK_EVENT,
  input wire logic [3:0] MCHK_SYNDROME,
  input wire logic CHKSTOP_EVENT,
  input wire logic INSN_COMPLETE,
  input wire logic INSN_16BIT,
  input wire logic INSN_VAR_PAGE,
  input wire logic IRQ_PENDING,
  // Power handshake
  input wire logic HALT_REQ,
  input wire logic STOP_REQ,
  // Status outputs
  output logic TARGET_PREFETCH,
  output logic [1:0] BR_STAT,
  output logic MCHK_OUT,
  output logic CHKSTOP_OUT,
  output logic [6:0] PROC_STAT,
  output logic HALTED,
  output logic STOPPED,
  output logic DOZE,
  output logic NAP,
  output logic SLEEP,
  output logic WAKEUP,
  output logic IRQ
);

  logic [31:0] ctrl_reg;
  logic [2:0] hw_config_reg;
  logic [3:0] machine_check_syndrome_reg;
  logic [CSP_IRQ_W-1:0] irq_stat_reg;
  logic [CSP_IRQ_W-1:0] irq_mask_reg;
  logic wake_req_reg;
  logic pending_reg;
  logic ack_reg;
  logic [31:0] rdata_next;
  logic [CSP_IRQ_W-1:0] irq_event;
  logic [CSP_IRQ_W-1:0] irq_clr;
  logic wr_acc;
  logic rd_acc;
  logic wait_enable_bit;
  logic mchk_clr;
  csp_state_e state_reg;
  csp_state_e state_next;

  assign wait_enable_bit = ctrl_reg[CSP_CTRL_WE_BIT];
  // Writes with byte 0 enabled commit at the edge that ends the cycle after the wait state
  assign wr_acc = AVS_WRITE && ack_reg && AVS_BYTEENABLE[0];
  assign rd_acc = AVS_READ && !ack_reg;
  assign mchk_clr = wr_acc && (AVS_ADDRESS == CSP_MACHINE_CHECK_SYNDROME_REG_IDX);
  assign irq_clr = (wr_acc && AVS_ADDRESS == CSP_IRQ_STAT_IDX) ?
    AVS_WRITEDATA[CSP_IRQ_W-1:0] : '0;

  // One wait state per access
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (AVS_READ || AVS_WRITE) && !ack_reg;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= CSP_ZERO32;
      hw_config_reg <= 3'h0;
      irq_mask_reg <= '0;
      wake_req_reg <= 1'b0;
    end else if (wr_acc) begin
      case (AVS_ADDRESS)
        CSP_CTRL_IDX: ctrl_reg <= {30'h0, AVS_WRITEDATA[1:0]};
        CSP_HWCFG_IDX: hw_config_reg <= AVS_WRITEDATA[2:0];
        CSP_IRQ_MASK_IDX: irq_mask_reg <= AVS_WRITEDATA[CSP_IRQ_W-1:0];
        CSP_WAKE_IDX: wake_req_reg <= AVS_WRITEDATA[0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_next = CSP_ZERO32;
    case (AVS_ADDRESS)
      CSP_CTRL_IDX: rdata_next = ctrl_reg;
      CSP_HWCFG_IDX: rdata_next = {29'h0, hw_config_reg};
      CSP_MACHINE_CHECK_SYNDROME_REG_IDX: rdata_next = {28'h0, machine_check_syndrome_reg};
      CSP_STATUS_IDX: rdata_next = {25'h0, PROC_STAT};
      CSP_IRQ_STAT_IDX: rdata_next = {27'h0, irq_stat_reg};
      CSP_IRQ_MASK_IDX: rdata_next = {27'h0, irq_mask_reg};
      CSP_WAKE_IDX: rdata_next = {31'h0, wake_req_reg};
      default: rdata_next = CSP_ZERO32;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      AVS_READDATA <= CSP_ZERO32;
      AVS_WAITREQUEST <= 1'b1;
      AVS_RESPONSE <= 2'h0;
    end else begin
      AVS_READDATA <= rd_acc ? rdata_next : CSP_ZERO32;
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_reg);
      AVS_RESPONSE <= (AVS_ADDRESS > CSP_WAKE_IDX) ? 2'h2 : 2'h0;
    end
  end

  // Syndrome bits set by events, cleared by writing one; set wins
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      machine_check_syndrome_reg <= 4'h0;
    end else begin
      machine_check_syndrome_reg <= (machine_check_syndrome_reg &
        ~(mchk_clr ? AVS_WRITEDATA[3:0] : 4'h0)) |
        (MCHK_EVENT ? MCHK_SYNDROME : 4'h0);
    end
  end

  // Core state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CSP_RUN: begin
        if (CHKSTOP_EVENT || ctrl_reg[CSP_CTRL_CHK_BIT]) begin
          state_next = CSP_CHKSTOP;
        end else if (STOP_REQ) begin
          state_next = CSP_STOP;
        end else if (HALT_REQ) begin
          state_next = CSP_HALT;
        end
      end
      CSP_HALT: begin
        if (CHKSTOP_EVENT) begin
          state_next = CSP_CHKSTOP;
        end else if (!HALT_REQ) begin
          state_next = CSP_RUN;
        end
      end
      CSP_STOP: begin
        if (CHKSTOP_EVENT) begin
          state_next = CSP_CHKSTOP;
        end else if (!STOP_REQ) begin
          state_next = CSP_RUN;
        end
      end
      CSP_CHKSTOP: state_next = CSP_CHKSTOP;
      default: state_next = CSP_RUN;
    endcase
  end

  // State register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= CSP_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Speculative target prefetch strobe
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      TARGET_PREFETCH <= 1'b0;
    end else begin
      TARGET_PREFETCH <= BTB_HIT && BTB_PREDICT_TAKEN;
    end
  end

  // Branch prefetch tracking
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pending_reg <= 1'b0;
      BR_STAT <= CSP_BR_NONE;
    end else begin
      if (BR_RESOLVE && pending_reg) begin
        BR_STAT <= BR_TAKEN ? CSP_BR_TAKEN : CSP_BR_NOT_TAKEN;
        pending_reg <= BTB_HIT && BTB_PREDICT_TAKEN;
      end else begin
        BR_STAT <= CSP_BR_NONE;
        if (BTB_HIT && BTB_PREDICT_TAKEN) begin
          pending_reg <= 1'b1;
        end
      end
    end
  end

  // Machine check and checkstop indications
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      MCHK_OUT <= 1'b0;
      CHKSTOP_OUT <= 1'b0;
    end else begin
      MCHK_OUT <= |machine_check_syndrome_reg;
      CHKSTOP_OUT <= (state_reg == CSP_CHKSTOP);
    end
  end

  // Halt and stop acknowledges
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      HALTED <= 1'b0;
      STOPPED <= 1'b0;
    end else begin
      HALTED <= (state_reg == CSP_HALT);
      STOPPED <= (state_reg == CSP_STOP);
    end
  end

  // Low-power requests and wake-up
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      DOZE <= 1'b0;
      NAP <= 1'b0;
      SLEEP <= 1'b0;
      WAKEUP <= 1'b0;
    end else begin
      DOZE <= wait_enable_bit && hw_config_reg[CSP_HW_DOZE_BIT];
      NAP <= wait_enable_bit && hw_config_reg[CSP_HW_NAP_BIT];
      SLEEP <= wait_enable_bit && hw_config_reg[CSP_HW_SLEEP_BIT];
      WAKEUP <= IRQ_PENDING || wake_req_reg;
    end
  end

  // Processor status code
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PROC_STAT <= 7'h0;
    end else begin
      case (state_reg)
        CSP_HALT: PROC_STAT <= {CSP_PS_HALTED, 2'h0};
        CSP_STOP: PROC_STAT <= {CSP_PS_STOPPED, 2'h0};
        CSP_CHKSTOP: PROC_STAT <= {CSP_PS_CHKSTOP, 2'h0};
        default: begin
          if (INSN_COMPLETE) begin
            PROC_STAT <= {CSP_PS_COMPLETE, INSN_16BIT, INSN_VAR_PAGE};
          end else begin
            PROC_STAT <= {CSP_PS_STALLED, 2'h0};
          end
        end
      endcase
    end
  end

  // Sticky interrupt status, set wins over clear
  assign irq_event = {BR_STAT != CSP_BR_NONE,
                      STOP_REQ && state_reg == CSP_RUN,
                      HALT_REQ && state_reg == CSP_RUN,
                      CHKSTOP_EVENT,
                      MCHK_EVENT};

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
    end
  end

  // Interrupt line follows the next status value
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(((irq_stat_reg & ~irq_clr) | irq_event) & irq_mask_reg);
    end
  end

endmodule : csp_core_status

/* csp_core_status_assertions.sv */
`timescale 1ns/1ns
module csp_status_chk
  import csp_pkg::*;
(
  input wire logic MCLK, RST_N, AVS_WAITREQUEST, BTB_HIT,
  input wire logic BTB_PREDICT_TAKEN, BR_RESOLVE, BR_TAKEN, MCHK_EVENT,
  input wire logic HALT_REQ, IRQ_PENDING, TARGET_PREFETCH, MCHK_OUT,
  input wire logic CHKSTOP_OUT, HALTED, STOPPED, WAKEUP,
  input wire logic [1:0] BR_STAT,
  input wire logic [6:0] PROC_STAT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  wait_pulse_a: assert property (
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("wait low too long");
  br_code_a: assert property (
    BR_STAT != 2'h0 |-> $past(BR_RESOLVE) &&
      BR_STAT == {1'h1, $past(BR_TAKEN)})
    else $error("bad branch code");
  prefetch_cause_a: assert property (
    TARGET_PREFETCH |-> $past(BTB_HIT && BTB_PREDICT_TAKEN))
    else $error("prefetch without taken hit");
  mchk_cause_a: assert property (
    $rose(MCHK_OUT) |-> $past(MCHK_EVENT, 2) || $past(MCHK_EVENT))
    else $error("machine check without event");
  chk_sticky_a: assert property (
    CHKSTOP_OUT |=> CHKSTOP_OUT && PROC_STAT[6:2] == CSP_PS_CHKSTOP)
    else $error("checkstop lost");
  halt_code_a: assert property (
    HALTED |-> PROC_STAT[6:2] == CSP_PS_HALTED && !STOPPED)
    else $error("halted code wrong");
  stop_code_a: assert property (
    STOPPED |-> PROC_STAT[6:2] == CSP_PS_STOPPED && !HALTED)
    else $error("stopped code wrong");
  ack_hold_a: assert property (
    $fell(HALTED) |-> !$past(HALT_REQ, 2) || STOPPED || CHKSTOP_OUT)
    else $error("halted dropped early");
  wake_irq_a: assert property (
    $past(IRQ_PENDING) |-> WAKEUP) else $error("no wake on irq");
endmodule : csp_status_chk
bind csp_core_status csp_status_chk chk (.*);

/* csp_power_ctl.sv */
`timescale 1ns/1ns
module csp_power_ctl (
  input wire logic MCLK, RST_N, halt_cmd, stop_cmd,
  input wire logic DOZE, NAP, SLEEP, WAKEUP,
  output logic HALT_REQ, STOP_REQ, lp_mode
);
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      HALT_REQ <= 1'h0;
      STOP_REQ <= 1'h0;
    end else begin
      HALT_REQ <= halt_cmd;
      STOP_REQ <= stop_cmd;
    end
  end
  // Clock gate state of the far side
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) lp_mode <= 1'h0;
    else if (WAKEUP) lp_mode <= 1'h0;
    else if (DOZE | NAP | SLEEP) lp_mode <= 1'h1;
  end
endmodule : csp_power_ctl

/* test_core_status_power_handshake.sv */
`timescale 1ns/1ns
module test_core_status_power_handshake;
  import csp_pkg::*;
  logic MCLK = 1'h0, RST_N = 1'h0, AVS_READ = 1'h0, AVS_WRITE = 1'h0;
  logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hf, MCHK_SYNDROME = 4'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
  logic [1:0] AVS_RESPONSE, BR_STAT, rsp;
  logic AVS_WAITREQUEST, BTB_HIT = 1'h0, BTB_PREDICT_TAKEN = 1'h0;
  logic BR_RESOLVE = 1'h0, BR_TAKEN = 1'h0, MCHK_EVENT = 1'h0;
  logic CHKSTOP_EVENT = 1'h0, INSN_COMPLETE = 1'h0, INSN_16BIT = 1'h0;
  logic INSN_VAR_PAGE = 1'h0, IRQ_PENDING = 1'h0, halt_cmd = 1'h0;
  logic stop_cmd = 1'h0, HALT_REQ, STOP_REQ, TARGET_PREFETCH, MCHK_OUT;
  logic CHKSTOP_OUT, HALTED, STOPPED, DOZE, NAP, SLEEP, WAKEUP, IRQ, lp_mode;
  logic [6:0] PROC_STAT;
  int err_count = 0, checks = 0;
  csp_core_status uut (.*);
  csp_power_ctl pwr (.*);
  initial forever #5 MCLK = ~MCLK;
  task automatic final_report;
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'h0 && n < 20);
    if (n >= 20) begin
      err_count++;
      final_report();
    end
    rd = AVS_READDATA;
    rsp = AVS_RESPONSE;
    AVS_READ <= 1'h0;
    AVS_WRITE <= 1'h0;
  endtask : bus
  task automatic t_branch;
    for (int t = 0; t < 2; t++) begin
      @(posedge MCLK);
      BTB_HIT <= 1'h1;
      BTB_PREDICT_TAKEN <= 1'h1;
      @(posedge MCLK);
      BTB_HIT <= 1'h0;
      BR_RESOLVE <= 1'h1;
      BR_TAKEN <= t[0];
      #1 cmp(TARGET_PREFETCH, 32'h1);
      @(posedge MCLK);
      BR_RESOLVE <= 1'h0;
      #1 cmp(BR_STAT, t ? CSP_BR_TAKEN : CSP_BR_NOT_TAKEN);
    end
    @(posedge MCLK);
    BTB_HIT <= 1'h1;
    BTB_PREDICT_TAKEN <= 1'h0;
    BR_RESOLVE <= 1'h1;
    @(posedge MCLK);
    BTB_HIT <= 1'h0;
    BR_RESOLVE <= 1'h0;
    #1 cmp(BR_STAT, CSP_BR_NONE);
    cmp(TARGET_PREFETCH, 32'h0);
    $display("branch test done");
  endtask : t_branch
  task automatic t_complete;
    for (int i = 0; i < 4; i++) begin
      @(posedge MCLK);
      INSN_COMPLETE <= 1'h1;
      INSN_16BIT <= i[1];
      INSN_VAR_PAGE <= i[0];
      @(posedge MCLK);
      #1 cmp(PROC_STAT, {CSP_PS_COMPLETE, i[1:0]});
    end
    INSN_COMPLETE <= 1'h0;
    $display("completion test done");
  endtask : t_complete
  task automatic t_mchk;
    bus(1'h1, CSP_IRQ_STAT_IDX, 32'h1f);
    bus(1'h1, CSP_IRQ_MASK_IDX, 32'h1f);
    @(posedge MCLK);
    MCHK_SYNDROME <= 4'h5;
    MCHK_EVENT <= 1'h1;
    @(posedge MCLK);
    MCHK_EVENT <= 1'h0;
    repeat (3) @(posedge MCLK);
    #1 cmp(MCHK_OUT, 32'h1);
    cmp(IRQ, 32'h1);
    bus(1'h0, CSP_MACHINE_CHECK_SYNDROME_REG_IDX, 32'h0);
    cmp(rd, 32'h5);
    cmp(rsp, 32'h0);
    bus(1'h1, CSP_IRQ_MASK_IDX, 32'h0);
    repeat (3) @(posedge MCLK);
    #1 cmp(IRQ, 32'h0);
    bus(1'h1, CSP_MACHINE_CHECK_SYNDROME_REG_IDX, 32'h5);
    bus(1'h1, CSP_IRQ_STAT_IDX, 32'h1f);
    repeat (3) @(posedge MCLK);
    #1 cmp(MCHK_OUT, 32'h0);
    bus(1'h0, CSP_IRQ_STAT_IDX, 32'h0);
    cmp(rd, 32'h0);
    $display("machine check test done");
  endtask : t_mchk
  task automatic t_power;
    for (int i = 0; i < 3; i++) begin
      bus(1'h1, CSP_HWCFG_IDX, 32'h1 << i);
      bus(1'h1, CSP_CTRL_IDX, 32'h0);
      repeat (3) @(posedge MCLK);
      #1 cmp({SLEEP, NAP, DOZE}, 32'h0);
      bus(1'h1, CSP_CTRL_IDX, 32'h1);
      repeat (3) @(posedge MCLK);
      #1 cmp({SLEEP, NAP, DOZE}, 32'h1 << i);
    end
    cmp(lp_mode, 32'h1);
    IRQ_PENDING <= 1'h1;
    repeat (3) @(posedge MCLK);
    #1 cmp(WAKEUP, 32'h1);
    cmp(lp_mode, 32'h0);
    IRQ_PENDING <= 1'h0;
    bus(1'h1, CSP_WAKE_IDX, 32'h1);
    repeat (3) @(posedge MCLK);
    #1 cmp(WAKEUP, 32'h1);
    bus(1'h1, CSP_WAKE_IDX, 32'h0);
    bus(1'h1, CSP_CTRL_IDX, 32'h0);
    $display("power test done");
  endtask : t_power
  task automatic t_halt_stop;
    @(posedge MCLK);
    halt_cmd <= 1'h1;
    repeat (3) @(posedge MCLK);
    #1 cmp(HALTED, 32'h1);
    cmp(PROC_STAT[6:2], CSP_PS_HALTED);
    stop_cmd <= 1'h1;
    repeat (3) @(posedge MCLK);
    #1 cmp({HALTED, STOPPED}, 32'h2);
    cmp(PROC_STAT[6:2], CSP_PS_HALTED);
    halt_cmd <= 1'h0;
    @(posedge MCLK);
    #1 cmp(HALTED, 32'h1);
    repeat (3) @(posedge MCLK);
    #1 cmp({HALTED, STOPPED}, 32'h1);
    cmp(PROC_STAT[6:2], CSP_PS_STOPPED);
    stop_cmd <= 1'h0;
    @(posedge MCLK);
    #1 cmp(STOPPED, 32'h1);
    repeat (2) @(posedge MCLK);
    #1 cmp({HALTED, STOPPED}, 32'h0);
    $display("halt stop test done");
  endtask : t_halt_stop
  task automatic t_chkstop;
    bus(1'h1, 4'h9, 32'hff);
    bus(1'h0, 4'h9, 32'h0);
    cmp(rsp, 32'h2);
    cmp(rd, 32'h0);
    @(posedge MCLK);
    CHKSTOP_EVENT <= 1'h1;
    @(posedge MCLK);
    CHKSTOP_EVENT <= 1'h0;
    repeat (2) @(posedge MCLK);
    #1 cmp(CHKSTOP_OUT, 32'h1);
    bus(1'h0, CSP_STATUS_IDX, 32'h0);
    cmp(rd[6:2], CSP_PS_CHKSTOP);
    @(posedge MCLK);
    RST_N <= 1'h0;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'h1;
    #1 cmp({CHKSTOP_OUT, PROC_STAT}, 32'h0);
    bus(1'h1, CSP_CTRL_IDX, 32'h2);
    repeat (3) @(posedge MCLK);
    #1 cmp(CHKSTOP_OUT, 32'h1);
    bus(1'h0, CSP_STATUS_IDX, 32'h0);
    cmp(rd[6:2], CSP_PS_CHKSTOP);
    $display("checkstop test done");
  endtask : t_chkstop
  initial begin
    repeat (10) @(posedge MCLK);
    RST_N <= 1'h1;
    #1 cmp({HALTED, STOPPED, CHKSTOP_OUT, MCHK_OUT, AVS_WAITREQUEST}, 32'h1);
    t_branch();
    t_complete();
    t_mchk();
    t_power();
    t_halt_stop();
    t_chkstop();
    final_report();
  end
endmodule : test_core_status_power_handshake
